// [rtl/bpc_pkg.sv]
// bpc_pkg: register map, field positions, reset values, timing and states
// assumes a 25 MHz system clock and a host tick of about 32 kHz
package bpc_pkg;

  // ==========================================================
  // register offsets
  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_DRIVE   = 4'h1;
  localparam logic [3:0] ADDR_POWER   = 4'h2;
  localparam logic [3:0] ADDR_FEATURE = 4'h3;
  localparam logic [3:0] ADDR_MONSEL  = 4'h4;
  localparam logic [3:0] ADDR_OLV     = 4'h5;
  localparam logic [3:0] ADDR_OLT     = 4'h6;
  localparam logic [3:0] ADDR_SCC     = 4'h7;
  localparam logic [3:0] ADDR_SCD     = 4'h8;

  // ==========================================================
  // field positions
  localparam int STS_SCC    = 0;
  localparam int STS_SCD    = 1;
  localparam int STS_OL     = 2;
  localparam int STS_WDF    = 3;
  localparam int STS_SLEEP  = 4;
  localparam int DRV_CLR    = 0;
  localparam int DRV_DSG    = 1;
  localparam int DRV_CHG    = 2;
  localparam int DRV_ZV     = 3;
  localparam int DRV_OD     = 4;
  localparam int PWR_SLEEP  = 0;
  localparam int PWR_SHIP   = 1;
  localparam int FEAT_AMP   = 0;
  localparam int FEAT_THERM = 5;

  // ==========================================================
  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [4:0] OLV_RST = 5'h00;
  localparam logic [3:0] OLT_RST = 4'h0;

  // ==========================================================
  // timing
  localparam int CLK_NS        = 40;
  localparam int WD_TIMEOUT_NS = 100000;
  localparam int WD_CYCLES     = WD_TIMEOUT_NS / CLK_NS;
  localparam int SC_STEP_TICKS = 2;
  localparam int OL_BASE_TICKS = 33;
  localparam int OL_STEP_TICKS = 66;

  // ==========================================================
  // power states
  typedef enum logic [2:0] {
    BPC_OFF    = 3'b000,
    BPC_INIT   = 3'b001,
    BPC_NORMAL = 3'b010,
    BPC_SLEEP  = 3'b011,
    BPC_SHIP   = 3'b100
  } bpc_state_t;

endpackage

// [rtl/bpc_core.sv]
// bpc_core: digital control of a battery protection front end
// assumes supply monitor inputs already synchronous; comparator, tick and sleep inputs go via sync
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// blanking delay counter
module bpc_blank (
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  input  wire logic       cmp_in,
  input  wire logic       tick_in,
  input  wire logic       enable_in,
  input  wire logic [9:0] limit_in,
  output logic            expired_out
);
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!cmp_in || !enable_in) begin
      cnt_nxt = 10'h000;
    end else if (tick_in && cnt_r < limit_in) begin
      cnt_nxt = cnt_r + 10'h001;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) cnt_r <= 10'h000;
    else cnt_r <= cnt_nxt;
  end

  // counter saturates, so a fault still present after a clear trips again
  assign expired_out = cmp_in && enable_in && (cnt_r >= limit_in);
endmodule // bpc_blank

// ============================================================
// control core
module bpc_core (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  // register port
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // supply and straps
  input  wire logic       supply_low_in,
  input  wire logic       supply_ok_in,
  input  wire logic       pack_present_in,
  input  wire logic       zero_volt_select_in,
  input  wire logic       sleep_pin_in,
  // comparators and tick
  input  wire logic       overload_cmp_in,
  input  wire logic       short_charge_cmp_in,
  input  wire logic       short_load_cmp_in,
  input  wire logic       host_tick_in,
  // FET drives and pins
  output logic            charge_fet_drive_out,
  output logic            discharge_fet_drive_out,
  output logic            zero_volt_fet_drive_out,
  output logic            alert_n_out,
  output logic            thermistor_bias_out,
  output logic            open_drain_out,
  output logic            regulator_enable_out,
  // analog settings and power state
  output logic      [4:0] overload_threshold_out,
  output logic      [3:0] short_charge_thr_out,
  output logic      [3:0] short_load_thr_out,
  output logic      [1:0] element_pick_out,
  output logic      [1:0] monitor_mode_out,
  output logic      [3:0] balance_out,
  output logic            monitor_amp_enable_out,
  output logic            ref_direct_out,
  output logic            ref_scaled_out,
  output bpc_pkg::bpc_state_t power_state_out
);
  import bpc_pkg::*;

  // ==========================================================
  // synchronisers: ol, scc, scd, tick, sleep
  logic [4:0] sy1_r;
  logic [4:0] sy2_r;
  logic [4:0] prev_r;
  logic       tick_rise;
  logic       sleep_chg;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sy1_r  <= 5'h00;
      sy2_r  <= 5'h00;
      prev_r <= 5'h00;
    end else begin
      sy1_r  <= {sleep_pin_in, host_tick_in, short_load_cmp_in,
                 short_charge_cmp_in, overload_cmp_in};
      sy2_r  <= sy1_r;
      prev_r <= sy2_r;
    end
  end
  assign tick_rise = sy2_r[3] & ~prev_r[3];
  assign sleep_chg = sy2_r[4] ^ prev_r[4];

  // ==========================================================
  // configuration registers
  logic [7:0] drive_r,  drive_nxt;
  logic [7:0] power_r,  power_nxt;
  logic [7:0] feat_r,   feat_nxt;
  logic [7:0] monsel_r, monsel_nxt;
  logic [4:0] olv_r,    olv_nxt;
  logic [3:0] olt_r,    olt_nxt;
  logic [7:0] scc_r,    scc_nxt;
  logic [7:0] scd_r,    scd_nxt;
  bpc_state_t state_r,  state_nxt;
  logic       cfg_clear;
  logic       clr_fall;
  logic       drv_wr;

  assign cfg_clear = (state_r == BPC_OFF) || (state_r == BPC_SHIP);
  assign drv_wr    = reg_wr_in && (reg_addr_in == ADDR_DRIVE);
  assign clr_fall  = drv_wr && drive_r[DRV_CLR] && !reg_wdata_in[DRV_CLR];

  // memory is lost with the regulator, so config clears when unpowered
  always_comb begin
    drive_nxt  = drive_r;
    power_nxt  = power_r;
    feat_nxt   = feat_r;
    monsel_nxt = monsel_r;
    olv_nxt    = olv_r;
    olt_nxt    = olt_r;
    scc_nxt    = scc_r;
    scd_nxt    = scd_r;
    if (cfg_clear) begin
      drive_nxt  = REG_RST;
      power_nxt  = REG_RST;
      feat_nxt   = REG_RST;
      monsel_nxt = REG_RST;
      olv_nxt    = OLV_RST;
      olt_nxt    = OLT_RST;
      scc_nxt    = REG_RST;
      scd_nxt    = REG_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_DRIVE:   drive_nxt  = {3'h0, reg_wdata_in[4:0]};
        ADDR_POWER:   power_nxt  = {6'h00, reg_wdata_in[1:0]};
        ADDR_FEATURE: feat_nxt   = reg_wdata_in;
        ADDR_MONSEL:  monsel_nxt = reg_wdata_in;
        ADDR_OLV:     olv_nxt    = reg_wdata_in[4:0];
        ADDR_OLT:     olt_nxt    = reg_wdata_in[3:0];
        ADDR_SCC:     scc_nxt    = reg_wdata_in;
        ADDR_SCD:     scd_nxt    = reg_wdata_in;
        default:      drive_nxt  = drive_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      drive_r  <= REG_RST;
      power_r  <= REG_RST;
      feat_r   <= REG_RST;
      monsel_r <= REG_RST;
      olv_r    <= OLV_RST;
      olt_r    <= OLT_RST;
      scc_r    <= REG_RST;
      scd_r    <= REG_RST;
    end else begin
      drive_r  <= drive_nxt;
      power_r  <= power_nxt;
      feat_r   <= feat_nxt;
      monsel_r <= monsel_nxt;
      olv_r    <= olv_nxt;
      olt_r    <= olt_nxt;
      scc_r    <= scc_nxt;
      scd_r    <= scd_nxt;
    end
  end

  // ==========================================================
  // power state machine
  logic zvs_r, zvs_nxt;

  always_comb begin
    state_nxt = state_r;
    zvs_nxt   = zvs_r;
    case (state_r)
      BPC_OFF: begin
        if (supply_ok_in) begin
          state_nxt = BPC_INIT;
          zvs_nxt   = zero_volt_select_in;
        end
      end
      BPC_INIT, BPC_NORMAL, BPC_SLEEP: begin
        if (power_r[PWR_SHIP] && !pack_present_in) state_nxt = BPC_SHIP;
        else if (sy2_r[4] || power_r[PWR_SLEEP]) state_nxt = BPC_SLEEP;
        else if (state_r == BPC_SLEEP) state_nxt = BPC_NORMAL;
        else if (drv_wr) state_nxt = BPC_NORMAL;
      end
      BPC_SHIP: begin
        if (pack_present_in) state_nxt = BPC_OFF;
      end
      default: state_nxt = BPC_OFF;
    endcase
    if (supply_low_in) state_nxt = BPC_OFF;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= BPC_OFF;
      zvs_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      zvs_r   <= zvs_nxt;
    end
  end

  // ==========================================================
  // blanking delays
  logic       active;
  logic [9:0] ol_lim, scc_lim, scd_lim;
  logic       ol_exp, scc_exp, scd_exp;

  assign active  = (state_r == BPC_INIT) || (state_r == BPC_NORMAL);
  assign ol_lim  = 10'(OL_BASE_TICKS + 32'(olt_r) * OL_STEP_TICKS);
  assign scc_lim = 10'(32'(scc_r[7:4]) * SC_STEP_TICKS);
  assign scd_lim = 10'(32'(scd_r[7:4]) * SC_STEP_TICKS);

  // overload comparator senses discharge direction only
  bpc_blank u_ol (
    .clk_sys_in  (clk_sys_in),
    .resetn_in   (resetn_in),
    .cmp_in      (sy2_r[0]),
    .tick_in     (tick_rise),
    .enable_in   (active),
    .limit_in    (ol_lim),
    .expired_out (ol_exp)
  );
  bpc_blank u_scc (
    .clk_sys_in  (clk_sys_in),
    .resetn_in   (resetn_in),
    .cmp_in      (sy2_r[1]),
    .tick_in     (tick_rise),
    .enable_in   (active),
    .limit_in    (scc_lim),
    .expired_out (scc_exp)
  );
  bpc_blank u_scd (
    .clk_sys_in  (clk_sys_in),
    .resetn_in   (resetn_in),
    .cmp_in      (sy2_r[2]),
    .tick_in     (tick_rise),
    .enable_in   (active),
    .limit_in    (scd_lim),
    .expired_out (scd_exp)
  );

  // ==========================================================
  // watchdog, fault latch, alert
  logic [11:0] wd_cnt_r, wd_cnt_nxt;
  logic        wd_on_r,  wd_on_nxt;
  logic [3:0]  flt_r,    flt_nxt;
  logic        alert_r,  alert_nxt;
  logic        arm_r,    arm_nxt;
  logic [3:0]  flt_set;
  logic        wd_exp;
  logic        st_rd;

  assign st_rd  = reg_rd_in && (reg_addr_in == ADDR_STATUS);
  assign wd_exp = active && wd_on_r && (wd_cnt_r >= 12'(WD_CYCLES - 1)) && !tick_rise;
  assign flt_set = {wd_exp, ol_exp, scd_exp, scc_exp};

  always_comb begin
    wd_on_nxt  = wd_on_r;
    wd_cnt_nxt = wd_cnt_r;
    if (!active) begin
      wd_on_nxt  = 1'b0;
      wd_cnt_nxt = 12'h000;
    end else if (tick_rise) begin
      wd_on_nxt  = 1'b1;
      wd_cnt_nxt = 12'h000;
    end else if (wd_on_r && wd_cnt_r < 12'(WD_CYCLES - 1)) begin
      wd_cnt_nxt = wd_cnt_r + 12'h001;
    end
    // set wins over a clear in the same cycle
    flt_nxt   = (flt_r & ~{4{clr_fall}}) | flt_set;
    arm_nxt   = clr_fall | (arm_r & ~st_rd);
    alert_nxt = (|(flt_set & ~flt_r)) | (sleep_chg & ~cfg_clear) |
                (alert_r & ~(arm_r & st_rd));
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wd_cnt_r <= 12'h000;
      wd_on_r  <= 1'b0;
      flt_r    <= 4'h0;
      arm_r    <= 1'b0;
      alert_r  <= 1'b0;
    end else begin
      wd_cnt_r <= wd_cnt_nxt;
      wd_on_r  <= wd_on_nxt;
      flt_r    <= flt_nxt;
      arm_r    <= arm_nxt;
      alert_r  <= alert_nxt;
    end
  end
  assign alert_n_out = ~alert_r;

  // ==========================================================
  // FET drives
  logic [2:0] fet_r, fet_nxt;
  logic       prot_ok;

  assign prot_ok = (flt_nxt == 4'h0);
  always_comb begin
    fet_nxt = 3'b000;
    if (state_nxt == BPC_INIT) begin
      fet_nxt[1] = zvs_nxt & prot_ok;
    end else if (state_nxt == BPC_NORMAL && prot_ok) begin
      fet_nxt = {drive_nxt[DRV_ZV], drive_nxt[DRV_CHG], drive_nxt[DRV_DSG]};
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) fet_r <= 3'b000;
    else fet_r <= fet_nxt;
  end
  assign discharge_fet_drive_out = fet_r[0];
  assign charge_fet_drive_out    = fet_r[1];
  assign zero_volt_fet_drive_out = fet_r[2];

  // ==========================================================
  // pins and analog settings; bias, open drain, balance and amp gated off outside active states
  assign regulator_enable_out   = !cfg_clear;
  assign thermistor_bias_out    = active & feat_r[FEAT_THERM];
  assign open_drain_out         = active & drive_r[DRV_OD];
  assign overload_threshold_out = olv_r;
  assign short_charge_thr_out   = scc_r[3:0];
  assign short_load_thr_out     = scd_r[3:0];
  assign element_pick_out       = monsel_r[1:0];
  assign monitor_mode_out       = monsel_r[3:2];
  assign balance_out            = active ? monsel_r[7:4] : 4'h0;
  assign monitor_amp_enable_out = active & feat_r[FEAT_AMP];
  assign ref_direct_out  = monitor_amp_enable_out && monsel_r[3:0] == 4'hc;
  assign ref_scaled_out  = monitor_amp_enable_out && monsel_r[3:0] == 4'h8;
  assign power_state_out = state_r;

  // ==========================================================
  // read port; reads are blanked while asleep
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd_in && active) begin
      case (reg_addr_in)
        ADDR_STATUS:  rdata_nxt = {3'h0, sy2_r[4], flt_r};
        ADDR_DRIVE:   rdata_nxt = drive_r;
        ADDR_POWER:   rdata_nxt = power_r;
        ADDR_FEATURE: rdata_nxt = feat_r;
        ADDR_MONSEL:  rdata_nxt = monsel_r;
        ADDR_OLV:     rdata_nxt = {3'h0, olv_r};
        ADDR_OLT:     rdata_nxt = {4'h0, olt_r};
        ADDR_SCC:     rdata_nxt = scc_r;
        ADDR_SCD:     rdata_nxt = scd_r;
        default:      rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) rdata_r <= 8'h00;
    else rdata_r <= rdata_nxt;
  end
  assign reg_rdata_out = rdata_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  sequence s_arm;
    clr_fall && flt_set == 4'h0;
  endsequence
  sequence s_quiet_read;
    st_rd && flt_set == 4'h0 && !sleep_chg;
  endsequence

  a_supply_off_all: assert property (supply_low_in |=> state_r == BPC_OFF && fet_r == 3'b000)
    else $error("supply low did not force off");
  a_start_init: assert property (state_r == BPC_OFF && supply_ok_in && !supply_low_in
    |=> state_r == BPC_INIT && zvs_r == $past(zero_volt_select_in))
    else $error("start-up did not enter init");
  a_fault_fets_off: assert property (flt_r != 4'h0 |-> fet_r == 3'b000)
    else $error("FET on while fault latched");
  a_fault_alert: assert property ($rose(flt_r[STS_OL]) |-> !alert_n_out)
    else $error("fault without alert");
  a_latch_hold: assert property (flt_r[STS_SCC] && !clr_fall |=> flt_r[STS_SCC])
    else $error("fault latch dropped");
  a_latch_clear: assert property (s_arm |=> flt_r == 4'h0)
    else $error("latch clear failed");
  a_sleep_alert: assert property (sleep_chg && active |=> !alert_n_out)
    else $error("sleep change missed alert");
  a_alert_release: assert property (s_arm ##2 s_quiet_read |=> alert_n_out)
    else $error("alert not released");
  a_wd_trip: assert property (active && wd_on_r && !tick_rise &&
    wd_cnt_r == 12'(WD_CYCLES - 1) |=> flt_r[STS_WDF] && fet_r == 3'b000)
    else $error("watchdog did not trip");
  a_sc_zero_delay: assert property (active && sy2_r[2] && scd_r[7:4] == 4'h0
    |=> flt_r[STS_SCD])
    else $error("zero delay short not immediate");
  a_ship_entry: assert property (state_r == BPC_NORMAL && power_r[PWR_SHIP] &&
    !pack_present_in && !supply_low_in |=> state_r == BPC_SHIP)
    else $error("ship mode not entered");

endmodule // bpc_core
`default_nettype wire

// [dv/bpc_host_tick.sv]
// bpc_host_tick: host time base that drives the protection core tick input
// assumes the bench clock and an active-low reset shared with the core
`timescale 1ns/100ps
`default_nettype none

module bpc_host_tick #(
  parameter int HALF = 10
) (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  // host control and tick
  input  wire logic run_in,
  output logic      host_tick_out
);
  int cnt_r;

  // ============================================================
  // tick generator
  // a stopped host parks the tick low; the watchdog then times out
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r         <= 0;
      host_tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt_r         <= 0;
      host_tick_out <= 1'b0;
    end else if (cnt_r == HALF - 1) begin
      cnt_r         <= 0;
      host_tick_out <= ~host_tick_out;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule // bpc_host_tick

`default_nettype wire

// [dv/tb_top.sv]
// tb_top: self-checking bench for the battery protection control core
// assumes bpc_pkg and bpc_core compiled first, host tick from bpc_host_tick
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module tb_top;
  import bpc_pkg::*;
  localparam int HALF = 10;
  logic        clk_sys_in, resetn_in, reg_wr_in, reg_rd_in, run;
  logic [3:0]  reg_addr_in;
  logic [7:0]  reg_wdata_in, reg_rdata_out, d, v;
  logic        supply_low_in, supply_ok_in, pack_present_in, zero_volt_select_in;
  logic        sleep_pin_in, overload_cmp_in, short_charge_cmp_in, short_load_cmp_in;
  logic        host_tick_in, charge_fet_drive_out, discharge_fet_drive_out;
  logic        zero_volt_fet_drive_out, alert_n_out, thermistor_bias_out, open_drain_out;
  logic        regulator_enable_out, monitor_amp_enable_out, ref_direct_out, ref_scaled_out;
  logic [4:0]  overload_threshold_out;
  logic [3:0]  short_charge_thr_out, short_load_thr_out, balance_out;
  logic [1:0]  element_pick_out, monitor_mode_out;
  bpc_state_t  power_state_out;
  logic [31:0] rnd;
  int          err_count, n_tests, cyc, nt, nc;
  int          mdl [9];
  int          msk [9] = '{8'hff, 8'h1f, 8'h03, 8'hff, 8'hff, 8'h1f, 8'h0f, 8'hff, 8'hff};

  bpc_core u_bpc_core (.clk_sys_in, .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .supply_low_in, .supply_ok_in, .pack_present_in,
    .zero_volt_select_in, .sleep_pin_in, .overload_cmp_in, .short_charge_cmp_in,
    .short_load_cmp_in, .host_tick_in, .charge_fet_drive_out, .discharge_fet_drive_out,
    .zero_volt_fet_drive_out, .alert_n_out, .thermistor_bias_out, .open_drain_out,
    .regulator_enable_out, .overload_threshold_out, .short_charge_thr_out,
    .short_load_thr_out, .element_pick_out, .monitor_mode_out, .balance_out,
    .monitor_amp_enable_out, .ref_direct_out, .ref_scaled_out, .power_state_out);

  bpc_host_tick #(.HALF(HALF)) u_bpc_host_tick (.clk_sys_in, .resetn_in, .run_in(run),
    .host_tick_out(host_tick_in));

  // ============================================================
  // clock, timeout and closing
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ============================================================
  // bus tasks and model
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(posedge clk_sys_in);
    reg_addr_in  <= a;
    reg_wdata_in <= dat;
    reg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    if (a < 9) mdl[a] = dat & msk[a];
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] dat);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 dat = reg_rdata_out;
  endtask

  // toggle latch clear, then read status to release the alert
  task automatic clear_alert();
    wr(ADDR_DRIVE, 8'(mdl[1] | 1));
    wr(ADDR_DRIVE, 8'(mdl[1] & 8'h1e));
    rd(ADDR_STATUS, d);
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic wait_st(input bpc_state_t s);
    for (int i = 0; i < 200 && power_state_out !== s; i++) begin
      @(posedge clk_sys_in);
      #1;
    end
  endtask

  // counts ticks and cycles until protection drops the discharge drive
  task automatic wait_off(output int t, output int c);
    logic pt;
    t = 0;
    c = 0;
    pt = host_tick_in;
    while (discharge_fet_drive_out !== 1'b0 && c < 6000) begin
      @(posedge clk_sys_in);
      #1;
      c++;
      if (host_tick_in && !pt) t++;
      pt = host_tick_in;
    end
  endtask

  // ============================================================
  // main sequence
  initial begin
    {resetn_in, reg_wr_in, reg_rd_in, run, reg_addr_in, reg_wdata_in} = '0;
    {supply_low_in, supply_ok_in, sleep_pin_in, overload_cmp_in} = '0;
    {short_charge_cmp_in, short_load_cmp_in} = '0;
    {pack_present_in, zero_volt_select_in} = 2'b11;
    rnd = 32'h560cf4f4;
    foreach (mdl[i]) mdl[i] = 0;
    repeat (12) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    run       <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    `CHK({charge_fet_drive_out, alert_n_out, regulator_enable_out}, 3'b010)
    supply_ok_in <= 1'b1;
    wait_st(BPC_INIT);
    `CHK(power_state_out, BPC_INIT)
    `CHK({charge_fet_drive_out, discharge_fet_drive_out, zero_volt_fet_drive_out}, 3'b100)
    `CHK({open_drain_out, thermistor_bias_out}, 2'b00)
    for (int i = 5; i < 9; i++) begin
      rd(4'(i), d);
      `CHK(d, 8'h00)
    end
    for (int i = 0; i < 4; i++) begin
      v = {4'h1 << i, 2'(i), 2'(3 - i)};
      wr(ADDR_MONSEL, v);
      `CHK({balance_out, monitor_mode_out, element_pick_out}, v)
    end
    rnd = xs(rnd);
    wr(ADDR_OLV, rnd[7:0]);
    `CHK(overload_threshold_out, rnd[4:0])
    wr(ADDR_SCC, {4'h2, rnd[11:8]});
    `CHK(short_charge_thr_out, rnd[11:8])
    wr(ADDR_SCD, {4'h0, rnd[15:12]});
    `CHK(short_load_thr_out, rnd[15:12])
    wr(ADDR_OLT, 8'hf0);
    for (int i = 5; i < 9; i++) begin
      rd(4'(i), d);
      `CHK(d, 8'(mdl[i]))
    end
    rd(4'hb, d);
    `CHK(d, 8'h00)
    wr(ADDR_FEATURE, 8'h21);
    `CHK(thermistor_bias_out, 1'b1)
    wr(ADDR_MONSEL, 8'h0c);
    `CHK({monitor_amp_enable_out, ref_direct_out, ref_scaled_out}, 3'b110)
    wr(ADDR_MONSEL, 8'h08);
    `CHK({ref_direct_out, ref_scaled_out}, 2'b01)
    wr(ADDR_DRIVE, 8'h16);
    repeat (2) @(posedge clk_sys_in);
    #1;
    `CHK(power_state_out, BPC_NORMAL)
    `CHK({zero_volt_fet_drive_out, charge_fet_drive_out, discharge_fet_drive_out}, 3'b011)
    `CHK(open_drain_out, 1'b1)
    // short in charge direction, delay code 2
    @(posedge clk_sys_in);
    short_charge_cmp_in <= 1'b1;
    wait_off(nt, nc);
    `CHK(nt >= 3 && nt <= 5, 1'b1)
    `CHK({charge_fet_drive_out, zero_volt_fet_drive_out, alert_n_out}, 3'b000)
    rd(ADDR_STATUS, d);
    `CHK(d, 8'h01)
    short_charge_cmp_in <= 1'b0;
    clear_alert();
    `CHK(alert_n_out, 1'b1)
    rd(ADDR_STATUS, d);
    `CHK(d, 8'h00)
    `CHK(discharge_fet_drive_out, 1'b1)
    // short in load direction, zero delay, clear while still present
    @(posedge clk_sys_in);
    short_load_cmp_in <= 1'b1;
    wait_off(nt, nc);
    `CHK(nc >= 3 && nc <= 4, 1'b1)
    rd(ADDR_STATUS, d);
    `CHK(d, 8'h02)
    clear_alert();
    rd(ADDR_STATUS, d);
    `CHK({d, discharge_fet_drive_out}, 9'h004)
    short_load_cmp_in <= 1'b0;
    clear_alert();
    // overload: a dropout after a short burst must restart the blanking count
    @(posedge clk_sys_in);
    overload_cmp_in <= 1'b1;
    repeat (20 * HALF) @(posedge clk_sys_in);
    overload_cmp_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    overload_cmp_in <= 1'b1;
    wait_off(nt, nc);
    `CHK(nt >= OL_BASE_TICKS - 1 && nt <= OL_BASE_TICKS + 1, 1'b1)
    rd(ADDR_STATUS, d);
    `CHK(d, 8'h04)
    overload_cmp_in <= 1'b0;
    clear_alert();
    // watchdog: host stops ticking
    @(negedge host_tick_in);
    @(posedge clk_sys_in);
    run <= 1'b0;
    wait_off(nt, nc);
    `CHK(nc + HALF >= WD_CYCLES - 8 && nc + HALF <= WD_CYCLES + 8, 1'b1)
    run <= 1'b1;
    repeat (50) @(posedge clk_sys_in);
    rd(ADDR_STATUS, d);
    `CHK(d, 8'h08)
    clear_alert();
    rd(ADDR_STATUS, d);
    `CHK(d, 8'h00)
    // sleep pin change
    sleep_pin_in <= 1'b1;
    wait_st(BPC_SLEEP);
    `CHK({power_state_out, alert_n_out, discharge_fet_drive_out}, {BPC_SLEEP, 2'b00})
    sleep_pin_in <= 1'b0;
    wait_st(BPC_NORMAL);
    clear_alert();
    `CHK(alert_n_out, 1'b1)
    // register-forced sleep: reads blanked, no alert raised
    wr(ADDR_POWER, 8'h01);
    wait_st(BPC_SLEEP);
    rd(ADDR_DRIVE, d);
    `CHK({d, discharge_fet_drive_out, alert_n_out}, 10'h001)
    wr(ADDR_POWER, 8'h00);
    wait_st(BPC_NORMAL);
    `CHK({power_state_out, discharge_fet_drive_out}, {BPC_NORMAL, 1'b1})
    // ship mode, pack return, then supply collapse
    pack_present_in <= 1'b0;
    wr(ADDR_POWER, 8'h02);
    wait_st(BPC_SHIP);
    `CHK({power_state_out, regulator_enable_out}, {BPC_SHIP, 1'b0})
    pack_present_in <= 1'b1;
    wait_st(BPC_INIT);
    `CHK(charge_fet_drive_out, 1'b1)
    supply_low_in <= 1'b1;
    wait_st(BPC_OFF);
    `CHK({power_state_out, charge_fet_drive_out, regulator_enable_out}, {BPC_OFF, 2'b00})
    test_done();
  end
endmodule // tb_top

`default_nettype wire
